/* hdl/epw_pkg.sv */
// Purpose: Constants for the page-write host controller of a byte-wide EEPROM
// Assumes: 40 MHz system clock
// Notes:   Times are in their printed unit; cycle counts are derived
package epw_pkg;
    // ****************************************
    // Clock and geometry
    // ****************************************
    localparam int CLK_MHZ          = 40;
    localparam int ADDR_W           = 17;
    localparam int DATA_W           = 8;
    localparam int PAGE_W           = 7;
    localparam int PAGE_BYTES       = 128;
    localparam int DATA_BIT_SEVEN   = 7;
    // ****************************************
    // Timing (ns / us / ms) and cycle counts
    // ****************************************
    localparam int WRITE_CYCLE_TIME_MS   = 10;
    localparam int WRITE_START_TIME_NS   = 250;
    localparam int LOAD_IDLE_TIME_US     = 100;
    localparam int LOCK_RELEASE_SETUP_US = 200;
    localparam int BYTE_LOAD_MAX_US      = 30;
    localparam int STROBE_PULSE_NS       = 350;
    localparam int ACCESS_TIME_NS        = 200;
    localparam int SETUP_HOLD_NS         = 150;
    localparam int WRITE_CYCLE_CYC   = WRITE_CYCLE_TIME_MS * 1000 * CLK_MHZ;
    localparam int WRITE_START_CYC   = (WRITE_START_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int LOAD_IDLE_CYC     = LOAD_IDLE_TIME_US * CLK_MHZ;
    localparam int LOCK_SETUP_CYC    = LOCK_RELEASE_SETUP_US * CLK_MHZ;
    localparam int BYTE_LOAD_CYC     = BYTE_LOAD_MAX_US * CLK_MHZ;
    localparam int STROBE_CYC        = (STROBE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC        = (ACCESS_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC          = (SETUP_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W             = 24;
    // ****************************************
    // States
    // ****************************************
    typedef enum logic [3:0] {
        EPW_IDLE    = 4'h0,
        EPW_RD_ACT  = 4'h1,
        EPW_RD_DONE = 4'h2,
        EPW_WR_SET  = 4'h3,
        EPW_WR_PUL  = 4'h4,
        EPW_WR_HOLD = 4'h5,
        EPW_WR_GAP  = 4'h6,
        EPW_BL_WAIT = 4'h7,
        EPW_POLL    = 4'h8,
        EPW_POLL_RD = 4'h9,
        EPW_LOCKED  = 4'hA
    } epw_state_t;
endpackage : epw_pkg

/* hdl/epw_host.sv */
// Purpose: Host controller driving a byte-wide page-write EEPROM over its pins
// Assumes: User keeps o_req_ready handshake; one page per write burst
// Notes:   Completion by ready/busy pin, bit-seven polling or full timeout
// Behaviour
// - Without polling or busy pin, wait full write cycle time.
// - With polling or busy pin, next access after write start time.
// - Strobes decode read, standby, deselect, write and write inhibit.
// - Next byte of page loaded within 30 us of previous.
// - Lock input high 200 us before any write access.
// - Lock held high 10 ms after last loaded byte; here the lock pin follows i_lock_req one cycle later and a request aborts the write.
`timescale 1ns/100ps
module epw_host
    import epw_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                i_mclk,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    // User request
    input  wire logic                i_req_valid,
    input  wire logic                i_req_write,
    input  wire logic                i_req_last,
    input  wire logic [ADDR_W-1:0]   i_req_addr,
    input  wire logic [DATA_W-1:0]   i_req_data,
    input  wire logic                i_mode_poll,
    input  wire logic                i_lock_req,
    output logic                     o_req_ready,
    output logic                     o_rd_valid,
    output logic [DATA_W-1:0]        o_rd_data,
    output logic                     o_busy,
    output logic                     o_prog_done,
    // Device pins
    output logic [ADDR_W-1:0]        o_addr,
    output logic                     o_chip_sel_n,
    output logic                     o_out_drv_n,
    output logic                     o_wr_strobe_n,
    output logic                     o_program_lock_n,
    output logic [DATA_W-1:0]        o_data_o,
    output logic                     o_data_oe_n,
    input  wire logic [DATA_W-1:0]   i_data_i,
    input  wire logic                i_ready_busy_n
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
    logic              rb_s1_reg, rb_s2_reg;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
            rb_s1_reg <= 1'b1;
            rb_s2_reg <= 1'b1;
        end else if (i_ce) begin
            dq_s1_reg <= i_data_i;
            dq_s2_reg <= dq_s1_reg;
            rb_s1_reg <= i_ready_busy_n;
            rb_s2_reg <= rb_s1_reg;
        end
    end
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = n[CNT_W-1:0];
    endfunction : cyc
    // ****************************************
    // Control state
    // ****************************************
    epw_state_t        st_reg, st_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [CNT_W-1:0]  tmo_reg, tmo_next;
    logic [CNT_W-1:0]  lck_reg, lck_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic [DATA_W-1:0] rdat_reg, rdat_next;
    logic              cs_n_reg, cs_n_next;
    logic              oe_n_reg, oe_n_next;
    logic              we_n_reg, we_n_next;
    logic              doe_n_reg, doe_n_next;
    logic              lk_n_reg, lk_n_next;
    logic              rdv_reg, rdv_next;
    logic              done_reg, done_next;
    logic              last_b7_reg, last_b7_next;
    logic              last_reg, last_next;
    logic              lock_ok;
    assign lock_ok = (lck_reg >= cyc(LOCK_SETUP_CYC));
    always_comb begin
        st_next      = st_reg;
        cnt_next     = cnt_reg;
        tmo_next     = tmo_reg;
        lck_next     = lck_reg;
        addr_next    = addr_reg;
        data_next    = data_reg;
        rdat_next    = rdat_reg;
        cs_n_next    = cs_n_reg;
        oe_n_next    = oe_n_reg;
        we_n_next    = we_n_reg;
        doe_n_next   = doe_n_reg;
        lk_n_next    = ~i_lock_req;
        rdv_next     = 1'b0;
        done_next    = 1'b0;
        last_b7_next = last_b7_reg;
        last_next    = last_reg;
        o_req_ready  = 1'b0;
        if (!lk_n_reg) begin
            lck_next = '0;
        end else if (!lock_ok) begin
            lck_next = lck_reg + 1'b1;
        end
        if (i_lock_req && st_reg != EPW_IDLE && st_reg != EPW_LOCKED) begin
            st_next    = EPW_LOCKED;
            cs_n_next  = 1'b1;
            oe_n_next  = 1'b1;
            we_n_next  = 1'b1;
            doe_n_next = 1'b1;
        end else begin
            unique case (st_reg)
                EPW_IDLE: begin
                    // Standby: chip select high, bus floating
                    cs_n_next = 1'b1;
                    tmo_next    = '0;
                    o_req_ready = i_ce && i_req_valid && !i_lock_req &&
                                  (!i_req_write || lock_ok);
                    if (o_req_ready) begin
                        addr_next = i_req_addr;
                        data_next = i_req_data;
                        cnt_next  = '0;
                        last_next = i_req_last;
                        st_next   = i_req_write ? EPW_WR_SET : EPW_RD_ACT;
                    end
                end
                EPW_RD_ACT: begin
                    cs_n_next = 1'b0;
                    oe_n_next = 1'b0;
                    cnt_next  = cnt_reg + 1'b1;
                    if (cnt_reg == cyc(ACCESS_CYC + 2)) begin
                        rdat_next = dq_s2_reg;
                        st_next   = EPW_RD_DONE;
                    end
                end
                EPW_RD_DONE: begin
                    cs_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    rdv_next  = 1'b1;
                    st_next   = EPW_IDLE;
                end
                EPW_WR_SET: begin
                    // Out drive high first so the write is not inhibited
                    oe_n_next  = 1'b1;
                    cs_n_next  = 1'b0;
                    doe_n_next = 1'b0;
                    cnt_next   = '0;
                    st_next    = EPW_WR_PUL;
                end
                EPW_WR_PUL: begin
                    // Address latched as strobe falls last, data as it rises
                    we_n_next = 1'b0;
                    cnt_next  = cnt_reg + 1'b1;
                    if (cnt_reg == cyc(STROBE_CYC)) begin
                        we_n_next    = 1'b1;
                        last_b7_next = data_reg[DATA_BIT_SEVEN];
                        cnt_next     = '0;
                        st_next      = EPW_WR_HOLD;
                    end
                end
                EPW_WR_HOLD: begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == cyc(HOLD_CYC)) begin
                        cs_n_next  = 1'b1;
                        doe_n_next = 1'b1;
                        cnt_next   = '0;
                        st_next    = last_reg ? EPW_BL_WAIT : EPW_WR_GAP;
                    end
                end
                EPW_WR_GAP: begin
                    cnt_next    = cnt_reg + 1'b1;
                    o_req_ready = i_ce && i_req_valid && i_req_write &&
                                  i_req_addr[ADDR_W-1:PAGE_W] ==
                                  addr_reg[ADDR_W-1:PAGE_W];
                    if (o_req_ready) begin
                        addr_next = i_req_addr;
                        data_next = i_req_data;
                        last_next = i_req_last;
                        st_next   = EPW_WR_SET;
                    end else if (cnt_reg >= cyc(BYTE_LOAD_CYC - 2 * HOLD_CYC)) begin
                        cnt_next = '0;
                        st_next  = EPW_BL_WAIT;
                    end
                end
                EPW_BL_WAIT: begin
                    cnt_next = cnt_reg + 1'b1;
                    tmo_next = tmo_reg + 1'b1;
                    if (cnt_reg >= cyc(LOAD_IDLE_CYC)) begin
                        cnt_next = '0;
                        st_next  = EPW_POLL;
                    end
                end
                EPW_POLL: begin
                    // Timeout counts the full write cycle from the last load
                    tmo_next = tmo_reg + 1'b1;
                    cnt_next = cnt_reg + 1'b1;
                    if (tmo_reg >= cyc(WRITE_CYCLE_CYC)) begin
                        done_next = 1'b1;
                        st_next   = EPW_IDLE;
                    end else if (cnt_reg >= cyc(WRITE_START_CYC)) begin
                        if (!i_mode_poll && rb_s2_reg) begin
                            done_next = 1'b1;
                            st_next   = EPW_IDLE;
                        end else if (i_mode_poll) begin
                            cnt_next = '0;
                            st_next  = EPW_POLL_RD;
                        end
                    end
                end
                EPW_POLL_RD: begin
                    cs_n_next = 1'b0;
                    oe_n_next = 1'b0;
                    tmo_next  = tmo_reg + 1'b1;
                    cnt_next  = cnt_reg + 1'b1;
                    if (cnt_reg == cyc(ACCESS_CYC + 2)) begin
                        cs_n_next = 1'b1;
                        oe_n_next = 1'b1;
                        cnt_next  = '0;
                        if (dq_s2_reg[DATA_BIT_SEVEN] == last_b7_reg) begin
                            done_next = 1'b1;
                            st_next   = EPW_IDLE;
                        end else begin
                            st_next   = EPW_POLL;
                        end
                    end
                end
                EPW_LOCKED: st_next = i_lock_req ? EPW_LOCKED : EPW_IDLE;
                default: st_next = EPW_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_reg      <= EPW_IDLE;
            cnt_reg     <= '0;
            tmo_reg     <= '0;
            lck_reg     <= '0;
            addr_reg    <= '0;
            data_reg    <= 8'h00;
            rdat_reg    <= 8'h00;
            cs_n_reg    <= 1'b1;
            oe_n_reg    <= 1'b1;
            we_n_reg    <= 1'b1;
            doe_n_reg   <= 1'b1;
            lk_n_reg    <= 1'b0;
            rdv_reg     <= 1'b0;
            done_reg    <= 1'b0;
            last_b7_reg <= 1'b0;
            last_reg    <= 1'b0;
        end else if (i_ce) begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            tmo_reg     <= tmo_next;
            lck_reg     <= lck_next;
            addr_reg    <= addr_next;
            data_reg    <= data_next;
            rdat_reg    <= rdat_next;
            cs_n_reg    <= cs_n_next;
            oe_n_reg    <= oe_n_next;
            we_n_reg    <= we_n_next;
            doe_n_reg   <= doe_n_next;
            lk_n_reg    <= lk_n_next;
            rdv_reg     <= rdv_next;
            done_reg    <= done_next;
            last_b7_reg <= last_b7_next;
            last_reg    <= last_next;
        end
    end
    // ****************************************
    // Outputs
    // ****************************************
    assign o_addr           = addr_reg;
    assign o_chip_sel_n     = cs_n_reg;
    assign o_out_drv_n      = oe_n_reg;
    assign o_wr_strobe_n    = we_n_reg;
    assign o_program_lock_n = lk_n_reg;
    assign o_data_o         = data_reg;
    assign o_data_oe_n      = doe_n_reg;
    assign o_rd_valid       = rdv_reg;
    assign o_rd_data        = rdat_reg;
    assign o_prog_done      = done_reg;
    assign o_busy           = (st_reg != EPW_IDLE);
endmodule : epw_host

/* bench/epw_host_asserts.sv */
// Purpose: Concurrent checks on the pins and handshake of the page-write host
// Assumes: Bound to every instance of the host controller
// Notes:   Watches only ports of the host
`timescale 1ns/100ps
module epw_host_checker
    import epw_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    // User side
    input  wire logic              i_req_valid,
    input  wire logic              i_req_write,
    input  wire logic              i_lock_req,
    input  wire logic              o_req_ready,
    input  wire logic              o_rd_valid,
    input  wire logic              o_prog_done,
    // Device pins
    input  wire logic [ADDR_W-1:0] o_addr,
    input  wire logic              o_chip_sel_n,
    input  wire logic              o_out_drv_n,
    input  wire logic              o_wr_strobe_n,
    input  wire logic              o_program_lock_n,
    input  wire logic [DATA_W-1:0] o_data_o,
    input  wire logic              o_data_oe_n
);
    // ****************************************
    // Cycle counters for lock setup and byte gaps
    // ****************************************
    localparam int LOCK_MIN = 8000;
    localparam int GAP_MAX  = 1200;
    localparam int IDLE_MIN = 4000;
    logic [13:0] lock_cnt_reg;
    logic [13:0] gap_cnt_reg;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_mclk) begin
        if (i_rst || !o_program_lock_n) begin
            lock_cnt_reg <= 14'h0000;
        end else if (lock_cnt_reg != 14'h3FFF) begin
            lock_cnt_reg <= lock_cnt_reg + 14'h0001;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            gap_cnt_reg <= 14'h3FFF;
        end else if (!o_wr_strobe_n) begin
            gap_cnt_reg <= 14'h0000;
        end else if (gap_cnt_reg != 14'h3FFF) begin
            gap_cnt_reg <= gap_cnt_reg + 14'h0001;
        end
    end
    chk_read_decode: assert property (!o_out_drv_n |-> !o_chip_sel_n && o_wr_strobe_n && o_data_oe_n)
        else $error("output drive low outside a read");
    chk_write_inhibit: assert property (!o_wr_strobe_n |-> o_out_drv_n && !o_chip_sel_n && !o_data_oe_n && o_program_lock_n)
        else $error("write strobe low outside a clean write");
    chk_addr_hold: assert property (!o_chip_sel_n && !$past(o_chip_sel_n) |-> $stable(o_addr))
        else $error("address moved while selected");
    chk_data_latch: assert property ($rose(o_wr_strobe_n) && o_program_lock_n |-> !o_data_oe_n && !o_chip_sel_n && $stable(o_data_o))
        else $error("data not held at write strobe rise");
    chk_lock_setup: assert property ($fell(o_wr_strobe_n) |-> lock_cnt_reg >= LOCK_MIN)
        else $error("write before lock release setup");
    chk_byte_gap: assert property ($fell(o_wr_strobe_n) |-> gap_cnt_reg < GAP_MAX || gap_cnt_reg >= IDLE_MIN)
        else $error("byte load outside window and before idle end");
    chk_lock_follow: assert property (i_ce && i_lock_req |=> !o_program_lock_n && o_wr_strobe_n && o_out_drv_n)
        else $error("lock request not applied");
    chk_lock_refuse: assert property (i_lock_req |-> !o_req_ready)
        else $error("request taken while locked");
    chk_no_done_lock: assert property (!o_program_lock_n |-> !o_prog_done)
        else $error("program done while locked");
    chk_read_answer: assert property (i_req_valid && o_req_ready && !i_req_write |-> ##[13:14] o_rd_valid)
        else $error("read answer late");
endmodule : epw_host_checker
bind epw_host epw_host_checker u_chk (.i_mclk, .i_rst, .i_ce, .i_req_valid, .i_req_write,
    .i_lock_req, .o_req_ready, .o_rd_valid, .o_prog_done, .o_addr, .o_chip_sel_n,
    .o_out_drv_n, .o_wr_strobe_n, .o_program_lock_n, .o_data_o, .o_data_oe_n);

/* bench/epw_eeprom_model.sv */
// Purpose: Behavioural byte-wide page-write EEPROM on the host's far side
// Assumes: Host keeps one page per load phase
// Notes:   Program time shortened; bits 6:0 during polling show array data
`timescale 1ns/100ps
module epw_eeprom_model
    import epw_pkg::*;
#(
    parameter int PROG_NS = 20000,
    parameter int IDLE_NS = 100000
)(
    // Device pins
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_chip_sel_n,
    input  wire logic              i_out_drv_n,
    input  wire logic              i_wr_strobe_n,
    input  wire logic              i_program_lock_n,
    input  wire logic [DATA_W-1:0] i_data,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_data_drv,
    output logic                   o_busy_pull
);
    logic [DATA_W-1:0]     mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0]     page_buf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] loaded = '0;
    logic [ADDR_W-1:0]     wr_addr = '0;
    logic [DATA_W-1:0]     last_byte = 8'h00;
    logic                  loading = 1'b0;
    realtime               t_last = 0;
    wire wr_act = (!i_chip_sel_n && !i_wr_strobe_n && i_out_drv_n &&
                   i_program_lock_n) === 1'b1;
    initial begin
        o_busy_pull = 1'b0;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    always @(posedge wr_act) wr_addr = i_addr;
    always @(negedge wr_act) begin
        page_buf[wr_addr[PAGE_W-1:0]] = i_data;
        loaded[wr_addr[PAGE_W-1:0]] = 1'b1;
        last_byte = i_data;
        t_last = $realtime;
        loading = 1'b1;
        o_busy_pull = 1'b1;
    end
    always begin
        wait (loading);
        while (loading) begin
            #100;
            if ($realtime - t_last >= IDLE_NS && i_chip_sel_n && i_wr_strobe_n) loading = 1'b0;
        end
        fork : prog_run
            begin
                #PROG_NS;
                for (int i = 0; i < PAGE_BYTES; i++)
                    if (loaded[i]) mem[{wr_addr[ADDR_W-1:PAGE_W], i[PAGE_W-1:0]}] = page_buf[i];
            end
            wait (!i_program_lock_n);
        join_any
        disable prog_run;
        loaded = '0;
        o_busy_pull = 1'b0;
    end
    assign o_data_drv = !i_chip_sel_n && !i_out_drv_n && i_wr_strobe_n && i_program_lock_n;
    assign o_data = o_busy_pull ? {~last_byte[DATA_BIT_SEVEN], mem[i_addr][6:0]} : mem[i_addr];
endmodule : epw_eeprom_model

/* bench/tb_eeprom_page_write_port.sv */
// Purpose: Self-checking bench for the EEPROM page-write host
// Assumes: Device model on the far side, clock enable held high
// Notes:   Undriven data bus shows a pattern that flips every cycle
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_eeprom_page_write_port;
    import epw_pkg::*;
    logic              i_mclk = 1'b0;
    logic              i_rst = 1'b1;
    logic              i_req_valid = 1'b0;
    logic              i_req_write = 1'b0;
    logic              i_req_last = 1'b0;
    logic [ADDR_W-1:0] i_req_addr = '0;
    logic [DATA_W-1:0] i_req_data = '0;
    logic              i_mode_poll = 1'b0;
    logic              i_lock_req = 1'b0;
    logic              o_req_ready, o_rd_valid, o_busy, o_prog_done, o_chip_sel_n, o_out_drv_n;
    logic              o_wr_strobe_n, o_program_lock_n, o_data_oe_n, dev_drv, dev_pull;
    logic [DATA_W-1:0] o_rd_data, o_data_o, dev_q, bus;
    logic [DATA_W-1:0] float_pat = 8'hA5;
    logic [ADDR_W-1:0] o_addr;
    wire               i_ready_busy_n = ~dev_pull;
    int                num_errors = 0;
    int                n_compared = 0;
    always #12.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) float_pat <= ~float_pat;
    assign bus = !o_data_oe_n ? o_data_o : (dev_drv ? dev_q : float_pat);
    epw_host DUT (.i_mclk, .i_rst, .i_ce(1'b1), .i_req_valid, .i_req_write, .i_req_last,
        .i_req_addr, .i_req_data, .i_mode_poll, .i_lock_req, .o_req_ready, .o_rd_valid,
        .o_rd_data, .o_busy, .o_prog_done, .o_addr, .o_chip_sel_n, .o_out_drv_n,
        .o_wr_strobe_n, .o_program_lock_n, .o_data_o, .o_data_oe_n, .i_data_i(bus),
        .i_ready_busy_n);
    epw_eeprom_model u_dev (.i_addr(o_addr), .i_chip_sel_n(o_chip_sel_n),
        .i_out_drv_n(o_out_drv_n), .i_wr_strobe_n(o_wr_strobe_n),
        .i_program_lock_n(o_program_lock_n), .i_data(bus), .o_data(dev_q),
        .o_data_drv(dev_drv), .o_busy_pull(dev_pull));
    task automatic req(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic last);
        int n;
        @(posedge i_mclk);
        i_req_valid <= 1'b1;
        i_req_write <= wr;
        i_req_addr  <= a;
        i_req_data  <= d;
        i_req_last  <= last;
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (o_req_ready !== 1'b1 && n < 20000);
        if (n >= 20000) num_errors++;
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
    endtask : req
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        int n;
        req(1'b0, a, 8'h00, 1'b0);
        for (n = 0; n < 40 && o_rd_valid !== 1'b1; n++) @(negedge i_mclk);
        `CHK({o_rd_valid, o_rd_data}, {1'b1, e})
    endtask : rd_chk
    task automatic wait_done(output int n);
        for (n = 0; n < 20000 && o_prog_done !== 1'b1; n++) @(negedge i_mclk);
    endtask : wait_done
    task automatic t_early_write;
        @(negedge i_mclk);
        `CHK({o_chip_sel_n, o_out_drv_n, o_wr_strobe_n, o_data_oe_n}, 4'hF)
        @(posedge i_mclk);
        i_req_valid <= 1'b1;
        i_req_write <= 1'b1;
        repeat (20) @(negedge i_mclk);
        `CHK({o_req_ready, o_wr_strobe_n}, 2'h1)
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
        rd_chk(17'h00080, 8'hFF);
        repeat (8100) @(posedge i_mclk);
    endtask : t_early_write
    task automatic t_page_pin;
        int n;
        req(1'b1, 17'h00085, 8'h11, 1'b0);
        req(1'b1, 17'h00080, 8'h22, 1'b0);
        req(1'b1, 17'h000FF, 8'h33, 1'b1);
        @(negedge i_mclk);
        `CHK({o_busy, i_ready_busy_n}, 2'h2)
        wait_done(n);
        `CHK(n >= 4800 && n < 20000, 1'b1)
        repeat (3) @(negedge i_mclk);
        `CHK({o_busy, i_ready_busy_n}, 2'h1)
        rd_chk(17'h00085, 8'h11);
        rd_chk(17'h00080, 8'h22);
        rd_chk(17'h000FF, 8'h33);
        rd_chk(17'h00086, 8'hFF);
    endtask : t_page_pin
    task automatic t_page_poll;
        int n;
        @(posedge i_mclk);
        i_mode_poll <= 1'b1;
        req(1'b1, 17'h00109, 8'h3C, 1'b1);
        wait_done(n);
        `CHK(n >= 4800 && n < 20000, 1'b1)
        rd_chk(17'h00109, 8'h3C);
    endtask : t_page_poll
    task automatic t_lock_abort;
        int n;
        int m;
        m = 0;
        @(posedge i_mclk);
        i_mode_poll <= 1'b0;
        req(1'b1, 17'h00181, 8'hC3, 1'b1);
        repeat (4200) @(posedge i_mclk);
        i_lock_req  <= 1'b1;
        i_req_valid <= 1'b1;
        i_req_write <= 1'b0;
        for (n = 0; n < 2000; n++) begin
            @(negedge i_mclk);
            if (o_prog_done === 1'b1) m++;
        end
        `CHK({m[3:0], o_req_ready, o_program_lock_n, i_ready_busy_n}, 7'h01)
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
        i_lock_req  <= 1'b0;
    endtask : t_lock_abort
    task automatic summarize;
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    initial begin
        #(60000 * 25);
        num_errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_early_write();
        t_page_pin();
        t_page_poll();
        t_lock_abort();
        summarize();
    end
endmodule : tb_eeprom_page_write_port
